//--- shared/gcil1_pkg.sv
package gcil1_pkg;
    localparam logic [7:0] REG_L1_CMD     = 8'h04;
    localparam logic [7:0] REG_READY_CODE = 8'h05;
    localparam logic [7:0] REG_GCI_MODE   = 8'h06;
    localparam logic [7:0] REG_MON_CTRL   = 8'h07;

    localparam logic [3:0] RST_L1_CMD     = 4'hF;
    localparam logic [3:0] RST_READY_CODE = 4'hC;
    localparam logic [4:0] RST_GCI_MODE   = 5'h00;
    localparam logic [3:0] RST_MON_CTRL   = 4'h0;

    localparam int GCR_MAC  = 7;
    localparam int GCR_TLP  = 4;
    localparam int GCR_GCI_REMOTE_LOOPBACK = 3;
    localparam int GCR_SPU  = 2;
    localparam int GCR_PD   = 1;
    localparam int GCR_GE   = 0;

    localparam int MOC_MONITOR_RX_INT_ENABLE = 3;
    localparam int MOC_MRC  = 2;
    localparam int MOC_MONITOR_TX_INT_ENABLE = 1;
    localparam int MOC_MXC  = 0;

    localparam logic [3:0] CI_ACTIVATE_REQUEST = 4'h8;
    localparam logic [3:0] CI_DEACT_CONFIRM    = 4'hF;
    localparam logic [3:0] CI_POWER_UP         = 4'h7;

    // frame layout, msb first on the downstream line; upstream sends the msb on the last fall
    localparam int FRAME_BITS = 32;
    localparam int FR_B1_LSB  = 24;
    localparam int FR_B2_LSB  = 16;
    localparam int FR_MON_LSB = 8;
    localparam int FR_D_LSB   = 6;
    localparam int FR_CI_LSB  = 2;
    localparam int FR_MR      = 1;
    localparam int FR_MX      = 0;
    localparam logic [4:0] FR_LAST_BIT = 5'h1F;

    typedef enum logic [1:0] {
        GCIL1_MON_IDLE = 2'b00,
        GCIL1_MON_SEND = 2'b01,
        GCIL1_MON_WAIT = 2'b11
    } gcil1_mon_t;

    function automatic logic [3:0] gcil1_ci(input logic [31:0] word);
        gcil1_ci = word[FR_CI_LSB +: 4];
    endfunction : gcil1_ci
endpackage : gcil1_pkg

//--- design/gcil1_sync.sv
`timescale 1ns/1ns
module gcil1_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule : gcil1_sync

//--- design/gcil1_frame.sv
`timescale 1ns/1ns
module gcil1_frame
    import gcil1_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        link_clk_in,
    input  wire logic        fsync_in,
    input  wire logic        rx_bit_in,
    input  wire logic [31:0] tx_word_in,
    output logic             tx_bit_out,
    output logic [31:0]      rx_word_out,
    output logic             frame_done_out
);
    logic        clk_d_r;
    logic        clk_d_nxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cnt_nxt;
    logic [31:0] rx_sh_r;
    logic [31:0] rx_sh_nxt;
    logic [31:0] rx_word_r;
    logic [31:0] rx_word_nxt;
    logic [31:0] tx_word_r;
    logic [31:0] tx_word_nxt;
    logic        tx_bit_r;
    logic        tx_bit_nxt;
    logic        done_r;
    logic        done_nxt;
    logic        rise;
    logic        fall;
    logic [4:0]  pos;

    assign rise = link_clk_in & ~clk_d_r;
    assign fall = ~link_clk_in & clk_d_r;

    // bits sampled on rising edges, launched on falling edges
    always_comb begin
        clk_d_nxt   = link_clk_in;
        cnt_nxt     = cnt_r;
        rx_sh_nxt   = rx_sh_r;
        rx_word_nxt = rx_word_r;
        tx_word_nxt = tx_word_r;
        tx_bit_nxt  = tx_bit_r;
        done_nxt    = 1'b0;
        pos         = 5'h00;
        if (rise) begin
            rx_sh_nxt = {rx_sh_r[30:0], rx_bit_in};
            cnt_nxt   = fsync_in ? 5'h01 : 5'(cnt_r + 5'h01);
            if (!fsync_in && cnt_r == FR_LAST_BIT) begin
                rx_word_nxt = {rx_sh_r[30:0], rx_bit_in};
                done_nxt    = 1'b1;
            end
            if (fsync_in) begin
                tx_word_nxt = tx_word_in;
            end
        end
        if (fall) begin
            // frame word is latched at sync so a frame never mixes two words
            pos        = 5'(FR_LAST_BIT - cnt_r);
            tx_bit_nxt = tx_word_r[pos];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            clk_d_r   <= 1'b0;
            cnt_r     <= 5'h00;
            rx_sh_r   <= 32'h0000_0000;
            rx_word_r <= 32'hFFFF_FFFF;
            tx_word_r <= 32'hFFFF_FFFF;
            tx_bit_r  <= 1'b1;
            done_r    <= 1'b0;
        end else begin
            clk_d_r   <= clk_d_nxt;
            cnt_r     <= cnt_nxt;
            rx_sh_r   <= rx_sh_nxt;
            rx_word_r <= rx_word_nxt;
            tx_word_r <= tx_word_nxt;
            tx_bit_r  <= tx_bit_nxt;
            done_r    <= done_nxt;
        end
    end

    assign tx_bit_out     = tx_bit_r;
    assign rx_word_out    = rx_word_r;
    assign frame_done_out = done_r;
endmodule : gcil1_frame

//--- design/gcil1_top.sv
// Contract
// - layer-1 command register drives command, reads back
// - gci enabled: command code goes to transceiver
// - programmable ready code marks activation indication
// - flag shows monitor transmission in progress
// - test loopback feeds upstream into downstream input
// - remote loopback returns received 2B+D channels
// - power-down acknowledge drives upstream line high unless software power-up is also set
// - software power-up pulls upstream line low unless power-down is also set
// - gci enable disables S/T layer one
// - receive enable gates monitor receive status
// - receive handshake control sets sent bit
// - code 1111 means deactivation confirmation
// - code 0111 means power-up indication
`timescale 1ns/1ns
module gcil1_top
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       gci_clk_in,
    input  wire logic       gci_fsync_in,
    input  wire logic       downstream_data_line_in,
    output logic            upstream_data_line_out,
    output logic            upstream_data_line_oe_out,
    output logic            st_layer1_enable_out,
    output logic      [3:0] layer1_cmd_bits_out,
    input  wire logic [7:0] b1_tx_in,
    input  wire logic [7:0] b2_tx_in,
    input  wire logic [1:0] d_tx_in,
    output logic      [7:0] b1_rx_out,
    output logic      [7:0] b2_rx_out,
    output logic      [1:0] d_rx_out,
    output logic            rx_frame_valid_out,
    input  wire logic       mon_tx_start_in,
    input  wire logic [7:0] mon_tx_data_in,
    output logic      [7:0] mon_rx_data_out,
    output logic      [3:0] indication_code_out,
    output logic            indication_code_change_out,
    output logic            deactivation_confirm_out,
    output logic            power_up_indication_out,
    output logic            activation_indication_out,
    output logic            monitor_data_received_out,
    output logic            monitor_end_of_reception_out,
    output logic            monitor_data_ack_out
);
    import gcil1_pkg::*;

    logic [3:0]  l1_cmd_r;
    logic [3:0]  l1_cmd_nxt;
    logic [3:0]  ready_code_r;
    logic [3:0]  ready_code_nxt;
    logic [4:0]  gci_mode_r;
    logic [4:0]  gci_mode_nxt;
    logic [3:0]  mon_ctrl_r;
    logic [3:0]  mon_ctrl_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;

    logic [2:0]  pins_sync;
    logic        rx_bit;
    logic        tx_bit;
    logic [31:0] tx_word;
    logic [31:0] rx_word;
    logic        frame_done;

    logic [3:0]  ci_last_r;
    logic [3:0]  ci_last_nxt;
    logic [3:0]  ci_code_r;
    logic [3:0]  ci_code_nxt;
    logic        icc_r;
    logic        icc_nxt;
    gcil1_mon_t  mon_st_r;
    gcil1_mon_t  mon_st_nxt;
    logic [7:0]  mon_tx_byte_r;
    logic [7:0]  mon_tx_byte_nxt;
    logic        mx_prev_r;
    logic        mx_prev_nxt;
    logic        mon_rx_act_r;
    logic        mon_rx_act_nxt;
    logic [7:0]  mon_rx_byte_r;
    logic [7:0]  mon_rx_byte_nxt;
    logic        mdr_r;
    logic        mdr_nxt;
    logic        mer_r;
    logic        mer_nxt;
    logic        mda_r;
    logic        mda_nxt;
    logic [7:0]  b1_rx_r;
    logic [7:0]  b1_rx_nxt;
    logic [7:0]  b2_rx_r;
    logic [7:0]  b2_rx_nxt;
    logic [1:0]  d_rx_r;
    logic [1:0]  d_rx_nxt;
    logic        rx_valid_r;
    logic        rx_valid_nxt;

    logic        ge;
    logic        software_power_up;
    logic        pd;
    logic        mac;
    logic        mx_tx;
    logic        up_level;
    logic        rx_mx;
    logic        rx_mr;

    assign ge  = gci_mode_r[GCR_GE];
    assign software_power_up = gci_mode_r[GCR_SPU];
    assign pd  = gci_mode_r[GCR_PD];
    assign mac = (mon_st_r != GCIL1_MON_IDLE);

    gcil1_sync #(
        .W(3)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .async_in   ({gci_clk_in, gci_fsync_in, downstream_data_line_in}),
        .sync_out   (pins_sync)
    );

    // external downstream input ignored while looped back internally
    assign rx_bit = gci_mode_r[GCR_TLP] ? up_level : pins_sync[0];

    gcil1_frame u_frame (
        .sys_clk_in     (sys_clk_in),
        .rst_in         (rst_in),
        .link_clk_in    (pins_sync[2]),
        .fsync_in       (pins_sync[1]),
        .rx_bit_in      (rx_bit),
        .tx_word_in     (tx_word),
        .tx_bit_out     (tx_bit),
        .rx_word_out    (rx_word),
        .frame_done_out (frame_done)
    );

    assign rx_mx = rx_word[FR_MX];
    assign rx_mr = rx_word[FR_MR];

    // handshake bits are active low on the line
    assign mx_tx = ~(mac | mon_ctrl_r[MOC_MXC]);

    always_comb begin
        tx_word = 32'hFFFF_FFFF;
        if (gci_mode_r[GCR_GCI_REMOTE_LOOPBACK]) begin
            tx_word[FR_B1_LSB +: 8] = rx_word[FR_B1_LSB +: 8];
            tx_word[FR_B2_LSB +: 8] = rx_word[FR_B2_LSB +: 8];
            tx_word[FR_D_LSB  +: 2] = rx_word[FR_D_LSB  +: 2];
        end else begin
            tx_word[FR_B1_LSB +: 8] = b1_tx_in;
            tx_word[FR_B2_LSB +: 8] = b2_tx_in;
            tx_word[FR_D_LSB  +: 2] = d_tx_in;
        end
        if (mac) begin
            tx_word[FR_MON_LSB +: 8] = mon_tx_byte_r;
        end
        tx_word[FR_CI_LSB +: 4] = l1_cmd_r;
        tx_word[FR_MR]          = mon_ctrl_r[MOC_MRC];
        tx_word[FR_MX]          = mx_tx;
    end

    // power handshake overrides frame data; both bits set sends data
    always_comb begin
        if (software_power_up && !pd) begin
            up_level = 1'b0;
        end else if (pd && !software_power_up) begin
            up_level = 1'b1;
        end else begin
            up_level = tx_bit;
        end
    end

    assign upstream_data_line_out    = up_level;
    assign upstream_data_line_oe_out = ge;
    assign st_layer1_enable_out      = ~ge;
    assign layer1_cmd_bits_out       = l1_cmd_r;

    always_comb begin
        l1_cmd_nxt     = l1_cmd_r;
        ready_code_nxt = ready_code_r;
        gci_mode_nxt   = gci_mode_r;
        mon_ctrl_nxt   = mon_ctrl_r;
        rdata_nxt      = rdata_r;
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_L1_CMD:     l1_cmd_nxt     = reg_wdata_in[3:0];
                REG_READY_CODE: ready_code_nxt = reg_wdata_in[3:0];
                REG_GCI_MODE:   gci_mode_nxt   = reg_wdata_in[4:0];
                REG_MON_CTRL:   mon_ctrl_nxt   = reg_wdata_in[3:0];
                default:        l1_cmd_nxt     = l1_cmd_r;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_L1_CMD:     rdata_nxt = {4'h0, l1_cmd_r};
                REG_READY_CODE: rdata_nxt = {4'h0, ready_code_r};
                REG_GCI_MODE:   rdata_nxt = {mac, 2'h0, gci_mode_r};
                REG_MON_CTRL:   rdata_nxt = {4'h0, mon_ctrl_r};
                default:        rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            l1_cmd_r     <= RST_L1_CMD;
            ready_code_r <= RST_READY_CODE;
            gci_mode_r   <= RST_GCI_MODE;
            mon_ctrl_r   <= RST_MON_CTRL;
            rdata_r      <= 8'h00;
        end else begin
            l1_cmd_r     <= l1_cmd_nxt;
            ready_code_r <= ready_code_nxt;
            gci_mode_r   <= gci_mode_nxt;
            mon_ctrl_r   <= mon_ctrl_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;

    always_comb begin
        ci_last_nxt     = ci_last_r;
        ci_code_nxt     = ci_code_r;
        icc_nxt         = 1'b0;
        mon_st_nxt      = mon_st_r;
        mon_tx_byte_nxt = mon_tx_byte_r;
        mx_prev_nxt     = mx_prev_r;
        mon_rx_act_nxt  = mon_rx_act_r;
        mon_rx_byte_nxt = mon_rx_byte_r;
        mdr_nxt         = 1'b0;
        mer_nxt         = 1'b0;
        mda_nxt         = 1'b0;
        b1_rx_nxt       = b1_rx_r;
        b2_rx_nxt       = b2_rx_r;
        d_rx_nxt        = d_rx_r;
        rx_valid_nxt    = 1'b0;
        if (frame_done && ge) begin
            // a code counts only after two equal frames, filtering bit errors
            ci_last_nxt = gcil1_ci(rx_word);
            if (gcil1_ci(rx_word) == ci_last_r && ci_last_r != ci_code_r) begin
                ci_code_nxt = ci_last_r;
                icc_nxt     = 1'b1;
            end
            b1_rx_nxt    = rx_word[FR_B1_LSB +: 8];
            b2_rx_nxt    = rx_word[FR_B2_LSB +: 8];
            d_rx_nxt     = rx_word[FR_D_LSB +: 2];
            rx_valid_nxt = 1'b1;
            mx_prev_nxt  = rx_mx;
            if (!rx_mx && mx_prev_r) begin
                mon_rx_byte_nxt = rx_word[FR_MON_LSB +: 8];
                mon_rx_act_nxt  = 1'b1;
                mdr_nxt         = mon_ctrl_r[MOC_MONITOR_RX_INT_ENABLE];
            end else if (rx_mx && mx_prev_r && mon_rx_act_r) begin
                mon_rx_act_nxt  = 1'b0;
                mer_nxt         = mon_ctrl_r[MOC_MONITOR_RX_INT_ENABLE];
            end
        end
        case (mon_st_r)
            GCIL1_MON_IDLE: begin
                // a start while busy is dropped, the host must poll first
                if (mon_tx_start_in && ge) begin
                    mon_tx_byte_nxt = mon_tx_data_in;
                    mon_st_nxt      = GCIL1_MON_SEND;
                end
            end
            GCIL1_MON_SEND: begin
                if (!ge) begin
                    mon_st_nxt = GCIL1_MON_IDLE;
                end else if (frame_done && !rx_mr) begin
                    mda_nxt    = mon_ctrl_r[MOC_MONITOR_TX_INT_ENABLE];
                    mon_st_nxt = GCIL1_MON_WAIT;
                end
            end
            GCIL1_MON_WAIT: begin
                if (!ge || (frame_done && rx_mr)) begin
                    mon_st_nxt = GCIL1_MON_IDLE;
                end
            end
            default: mon_st_nxt = GCIL1_MON_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ci_last_r     <= CI_DEACT_CONFIRM;
            ci_code_r     <= CI_DEACT_CONFIRM;
            icc_r         <= 1'b0;
            mon_st_r      <= GCIL1_MON_IDLE;
            mon_tx_byte_r <= 8'hFF;
            mx_prev_r     <= 1'b1;
            mon_rx_act_r  <= 1'b0;
            mon_rx_byte_r <= 8'h00;
            mdr_r         <= 1'b0;
            mer_r         <= 1'b0;
            mda_r         <= 1'b0;
            b1_rx_r       <= 8'hFF;
            b2_rx_r       <= 8'hFF;
            d_rx_r        <= 2'h3;
            rx_valid_r    <= 1'b0;
        end else begin
            ci_last_r     <= ci_last_nxt;
            ci_code_r     <= ci_code_nxt;
            icc_r         <= icc_nxt;
            mon_st_r      <= mon_st_nxt;
            mon_tx_byte_r <= mon_tx_byte_nxt;
            mx_prev_r     <= mx_prev_nxt;
            mon_rx_act_r  <= mon_rx_act_nxt;
            mon_rx_byte_r <= mon_rx_byte_nxt;
            mdr_r         <= mdr_nxt;
            mer_r         <= mer_nxt;
            mda_r         <= mda_nxt;
            b1_rx_r       <= b1_rx_nxt;
            b2_rx_r       <= b2_rx_nxt;
            d_rx_r        <= d_rx_nxt;
            rx_valid_r    <= rx_valid_nxt;
        end
    end

    assign indication_code_out          = ci_code_r;
    assign indication_code_change_out   = icc_r;
    assign deactivation_confirm_out     = (ci_code_r == CI_DEACT_CONFIRM);
    assign power_up_indication_out      = (ci_code_r == CI_POWER_UP);
    assign activation_indication_out    = ge && (ci_code_r == ready_code_r);
    assign monitor_data_received_out    = mdr_r;
    assign monitor_end_of_reception_out = mer_r;
    assign monitor_data_ack_out         = mda_r;
    assign mon_rx_data_out              = mon_rx_byte_r;
    assign b1_rx_out                    = b1_rx_r;
    assign b2_rx_out                    = b2_rx_r;
    assign d_rx_out                     = d_rx_r;
    assign rx_frame_valid_out           = rx_valid_r;
endmodule : gcil1_top

//--- testbench/gcil1_properties.sv
`timescale 1ns/1ns
module gcil1_properties
    import gcil1_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic [7:0] reg_rdata_out,
    input  wire logic       upstream_data_line_out,
    input  wire logic       upstream_data_line_oe_out,
    input  wire logic       st_layer1_enable_out,
    input  wire logic [3:0] layer1_cmd_bits_out,
    input  wire logic       rx_frame_valid_out,
    input  wire logic [3:0] indication_code_out,
    input  wire logic       indication_code_change_out,
    input  wire logic       deactivation_confirm_out,
    input  wire logic       monitor_data_received_out,
    input  wire logic       monitor_data_ack_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    logic monitor_rx_int_enable_r;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            monitor_rx_int_enable_r <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == REG_MON_CTRL) begin
            monitor_rx_int_enable_r <= reg_wdata_in[MOC_MONITOR_RX_INT_ENABLE];
        end
    end
    wire logic gcr_wr = reg_wr_in && reg_addr_in == REG_GCI_MODE;
    property p_cmd_wr;
        reg_wr_in && reg_addr_in == REG_L1_CMD
            |=> {4'h0, layer1_cmd_bits_out} == ($past(reg_wdata_in) & 8'h0F);
    endproperty
    a_cmd_wr: assert property (p_cmd_wr) else $error("command not taken");
    property p_rd_cmd;
        reg_rd_in && !reg_wr_in && reg_addr_in == REG_L1_CMD
            |=> reg_rdata_out == {4'h0, $past(layer1_cmd_bits_out)};
    endproperty
    a_rd_cmd: assert property (p_rd_cmd) else $error("command readback wrong");
    property p_rsvd;
        reg_rd_in && reg_addr_in != REG_GCI_MODE |=> reg_rdata_out[7:4] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_ge;
        upstream_data_line_oe_out == !st_layer1_enable_out;
    endproperty
    a_ge: assert property (p_ge) else $error("enable and st layer disagree");
    property p_spu;
        gcr_wr && reg_wdata_in[2:0] == 3'b101 |=> ##[0:4] !upstream_data_line_out;
    endproperty
    a_spu: assert property (p_spu) else $error("upstream not pulled low");
    property p_pd;
        gcr_wr && reg_wdata_in[2:0] == 3'b011 |=> ##[0:4] upstream_data_line_out;
    endproperty
    a_pd: assert property (p_pd) else $error("upstream not driven high");
    property p_dc;
        deactivation_confirm_out == (indication_code_out == CI_DEACT_CONFIRM);
    endproperty
    a_dc: assert property (p_dc) else $error("deactivation flag wrong");
    property p_mdr;
        monitor_data_received_out |-> monitor_rx_int_enable_r;
    endproperty
    a_mdr: assert property (p_mdr) else $error("receive status not masked");
    property p_frm;
        rx_frame_valid_out |-> upstream_data_line_oe_out ##1 !rx_frame_valid_out;
    endproperty
    a_frm: assert property (p_frm) else $error("frame pulse wrong");
    c_frm: cover property (rx_frame_valid_out);
    c_icc: cover property (indication_code_change_out);
    c_ack: cover property (monitor_data_ack_out);
endmodule : gcil1_properties
bind gcil1_top gcil1_properties chk_u (.*);

//--- testbench/gcil1_xcvr_model.sv
`timescale 1ns/1ns
module gcil1_xcvr_model (
    input  wire logic upstream_in,
    output logic      link_clk_out,
    output logic      fsync_out,
    output logic      down_out
);
    logic [31:0] up_word;
    initial begin
        link_clk_out = 1'b0;
        fsync_out    = 1'b0;
        down_out     = 1'b1;
        up_word      = 32'h0;
    end
    task automatic frame(input logic [31:0] w);
        fsync_out = 1'b1;
        down_out  = w[31];
        #400;
        for (int i = 0; i < 32; i++) begin
            link_clk_out = 1'b1;
            #400;
            link_clk_out = 1'b0;
            fsync_out    = 1'b0;
            down_out     = (i < 31) ? w[30-i] : ~w[0];
            #390;
            // each fall carries the next bit; the msb leaves on the last fall
            up_word[5'(30 - i)] = upstream_in;
            #10;
        end
    endtask : frame
endmodule : gcil1_xcvr_model

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import gcil1_pkg::*;
    logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, mon_tx_start_in, rd_d;
    logic [7:0] reg_addr_in, reg_wdata_in, b1_tx_in, b2_tx_in, mon_tx_data_in, gb1, gb2, v;
    logic [7:0] reg_rdata_out, b1_rx_out, b2_rx_out, mon_rx_data_out;
    logic [1:0] d_tx_in, d_rx_out, gd, hs_e;
    logic [3:0] layer1_cmd_bits_out, indication_code_out, cmd;
    logic [3:0] codes [3];
    logic [17:0] save;
    logic gci_clk_in, gci_fsync_in, downstream_data_line_in, upstream_data_line_out;
    logic upstream_data_line_oe_out, st_layer1_enable_out, rx_frame_valid_out;
    logic indication_code_change_out, deactivation_confirm_out, power_up_indication_out;
    logic activation_indication_out, monitor_data_received_out;
    logic monitor_end_of_reception_out, monitor_data_ack_out;
    int miscompares, tests_run, icc_n, mdr_n, mer_n, ack_n, n0, n1;
    logic [7:0] exp_q [$];
    gcil1_top dut_u (.*);
    gcil1_xcvr_model xcvr_u (
        .upstream_in  (upstream_data_line_out),
        .link_clk_out (gci_clk_in),
        .fsync_out    (gci_fsync_in),
        .down_out     (downstream_data_line_in)
    );
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    always @(posedge sys_clk_in) begin
        rd_d <= reg_rd_in && !rst_in;
        if (rd_d) check(reg_rdata_out, exp_q.pop_front());
        icc_n <= icc_n + (indication_code_change_out === 1'b1);
        mdr_n <= mdr_n + (monitor_data_received_out === 1'b1);
        mer_n <= mer_n + (monitor_end_of_reception_out === 1'b1);
        ack_n <= ack_n + (monitor_data_ack_out === 1'b1);
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        reg_addr_in  = a;
        reg_wdata_in = d;
        reg_wr_in    = 1'b1;
        @(negedge sys_clk_in);
        reg_wr_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_rd_in   = 1'b1;
        exp_q.push_back(e);
        @(negedge sys_clk_in);
        reg_rd_in = 1'b0;
        @(negedge sys_clk_in);
    endtask : rd
    task automatic wait_up(input logic lvl);
        int n;
        n = 0;
        while (upstream_data_line_out !== lvl && n < 20) begin
            @(negedge sys_clk_in);
            n++;
        end
        if (n == 20) begin
            miscompares++;
            final_report();
        end
    endtask : wait_up
    task automatic xfer(input logic [7:0] mon, input logic [3:0] ci, input logic [1:0] hs);
        xcvr_u.frame({gb1, gb2, mon, gd, ci, hs});
        repeat (6) @(negedge sys_clk_in);
    endtask : xfer
    initial begin
        #5_000_000;
        miscompares++;
        final_report();
    end
    initial begin
        rst_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        mon_tx_start_in = 1'b0;
        b1_tx_in = 8'($urandom(93744));
        b2_tx_in = 8'($urandom);
        d_tx_in = 2'($urandom);
        mon_tx_data_in = 8'h00;
        gb1 = 8'hFF;
        gb2 = 8'hFF;
        gd = 2'h3;
        repeat (2) @(negedge sys_clk_in);
        rst_in = 1'b0;
        rd(REG_L1_CMD, 8'h0F);
        rd(REG_READY_CODE, 8'h0C);
        rd(REG_GCI_MODE, 8'h00);
        rd(REG_MON_CTRL, 8'h00);
        rd(8'h08, 8'h00);
        check(st_layer1_enable_out, 1'b1);
        wr(REG_L1_CMD, 8'hFF);
        wr(REG_READY_CODE, 8'hFF);
        wr(REG_MON_CTRL, 8'hFF);
        wr(REG_GCI_MODE, 8'hE0);
        wr(8'h03, 8'hFF);
        rd(REG_L1_CMD, 8'h0F);
        rd(REG_READY_CODE, 8'h0F);
        rd(REG_MON_CTRL, 8'h0F);
        rd(REG_GCI_MODE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(REG_L1_CMD, v);
            check(layer1_cmd_bits_out, v[3:0]);
            rd(REG_L1_CMD, {4'h0, v[3:0]});
        end
        wr(REG_GCI_MODE, 8'h01);
        check({st_layer1_enable_out, upstream_data_line_oe_out}, 2'b01);
        wr(REG_GCI_MODE, 8'h05);
        wait_up(1'b0);
        wr(REG_GCI_MODE, 8'h03);
        wait_up(1'b1);
        wr(REG_MON_CTRL, 8'h00);
        wr(REG_READY_CODE, 8'h03);
        wr(REG_L1_CMD, 8'h0F);
        wr(REG_GCI_MODE, 8'h05);
        cmd = 4'h0;
        hs_e = 2'b00;
        codes = '{CI_POWER_UP, 4'h3, CI_DEACT_CONFIRM};
        for (int k = 0; k < 3; k++) begin
            n0 = icc_n;
            xfer(8'hFF, codes[k], 2'b11);
            check(xcvr_u.up_word[5:0], {cmd, hs_e});
            xfer(8'hFF, codes[k], 2'b11);
            check(indication_code_out, codes[k]);
            check(power_up_indication_out, codes[k] == CI_POWER_UP);
            check(deactivation_confirm_out, codes[k] == CI_DEACT_CONFIRM);
            check(activation_indication_out, codes[k] == 4'h3);
            check(icc_n - n0, 1);
            if (k == 0) begin
                wr(REG_L1_CMD, {4'h0, CI_ACTIVATE_REQUEST});
                wr(REG_GCI_MODE, 8'h01);
                cmd = CI_ACTIVATE_REQUEST;
                hs_e = 2'b01;
            end
        end
        gb1 = 8'($urandom);
        gb2 = 8'($urandom);
        gd = 2'($urandom);
        save = {gb1, gb2, gd};
        wr(REG_GCI_MODE, 8'h09);
        xfer(8'hFF, 4'hF, 2'b11);
        check({b1_rx_out, b2_rx_out, d_rx_out}, save);
        gb1 = ~gb1;
        xfer(8'hFF, 4'hF, 2'b11);
        check({xcvr_u.up_word[31:16], xcvr_u.up_word[7:6]}, save);
        gb1 = 8'hFF;
        gb2 = 8'hFF;
        gd = 2'h3;
        wr(REG_GCI_MODE, 8'h15);
        xfer(8'hFF, 4'hF, 2'b11);
        check({b1_rx_out, b2_rx_out, d_rx_out}, 18'h0);
        wr(REG_GCI_MODE, 8'h01);
        xfer(8'hFF, 4'hF, 2'b11);
        wr(REG_MON_CTRL, 8'h06);
        rd(REG_GCI_MODE, 8'h01);
        v = 8'($urandom);
        @(negedge sys_clk_in);
        mon_tx_data_in = v;
        mon_tx_start_in = 1'b1;
        @(negedge sys_clk_in);
        mon_tx_start_in = 1'b0;
        rd(REG_GCI_MODE, 8'h81);
        n0 = ack_n;
        xfer(8'hFF, 4'hF, 2'b01);
        check({xcvr_u.up_word[15:8], xcvr_u.up_word[1:0]}, {v, 2'b10});
        check(ack_n - n0, 1);
        xfer(8'hFF, 4'hF, 2'b11);
        rd(REG_GCI_MODE, 8'h01);
        for (int m = 0; m < 2; m++) begin
            wr(REG_MON_CTRL, {4'h0, m[0], 3'b000});
            n0 = mdr_n;
            n1 = mer_n;
            v = 8'($urandom);
            xfer(8'hFF, 4'hF, 2'b11);
            xfer(v, 4'hF, 2'b10);
            xfer(8'hFF, 4'hF, 2'b11);
            xfer(8'hFF, 4'hF, 2'b11);
            check(2 * (mdr_n - n0) + (mer_n - n1), 3 * m);
        end
        check(mon_rx_data_out, v);
        final_report();
    end
endmodule : testbench
